//--- sdrbrp_pkg.sv
// ============================================================
// Shared constants for the bank, row and precharge controller
package sdrbrp_pkg;

  // ==========================================================
  // Array geometry
  localparam int BANK_GRP_W = 1;
  localparam int BANK_IDX_W = 2;
  localparam int BANK_W = BANK_GRP_W + BANK_IDX_W;
  localparam int BANKS = 8;
  localparam int ROW_W = 15;
  localparam int DQ_W = 16;

  // ==========================================================
  // Address bit positions sampled with commands
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int BURST_CHOP_BIT = 12;

  // ==========================================================
  // Timing counts in link clock cycles
  localparam int READ_LATENCY_NCK = 11;
  localparam int WRITE_LATENCY_NCK = 9;
  localparam int PRECHARGE_PERIOD_NCK = 11;
  localparam int ACTIVE_TO_CLOSE_MIN_NCK = 28;
  localparam int CNT_W = 7;

  // ==========================================================
  // Burst lengths and postamble in link clock half periods
  localparam int EIGHT_BEAT_HALVES = 8;
  localparam int CHOP_FOUR_HALVES = 4;
  localparam int POSTAMBLE_HALVES = 1;

  // ==========================================================
  // Bit positions inside the synchronised pin bus
  localparam int PIN_CK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_ACT_N = 2;
  localparam int PIN_RAS_N = 3;
  localparam int PIN_CAS_N = 4;
  localparam int PIN_WE_N = 5;
  localparam int PIN_BG = 6;
  localparam int PIN_BA = 7;
  localparam int PIN_ADDR = PIN_BA + BANK_IDX_W;
  localparam int PIN_DQ = PIN_ADDR + ROW_W;
  localparam int PIN_W = PIN_DQ + DQ_W;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ACT,
    CMD_PRE,
    CMD_RD,
    CMD_WR
  } sdrbrp_cmd_type;

  typedef enum logic [2:0] {
    RD_IDLE,
    RD_WAIT,
    RD_PRE,
    RD_BURST,
    RD_POST
  } sdrbrp_rd_state_type;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_WAIT,
    WR_BURST
  } sdrbrp_wr_state_type;

endpackage

//--- sdrbrp_sync.sv
`timescale 1ns/1ps
// ============================================================
// Three stage pin synchroniser, a bit changes once stages two and three agree
module sdrbrp_sync #(
  parameter int W = 8
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] pin_in, // Asynchronous pins
  output logic [W-1:0] pin_out // Filtered synchronous copy
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else if (ce) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
    end
  end

  assign pin_out = out_q;
endmodule // sdrbrp_sync

//--- sdrbrp_buf.sv
`timescale 1ns/1ps
// ============================================================
// Two entry buffer: an output register plus one spare slot
module sdrbrp_buf #(
  parameter int W = 16
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Sink takes word
  output logic [W-1:0] out_data, // Word out
  output logic empty // Nothing held
);
  logic [W-1:0] out_q;
  logic [W-1:0] spare_q;
  logic out_v_q;
  logic spare_v_q;
  logic push;
  logic pop;

  assign in_ready = ~spare_v_q;
  assign push = in_valid & ~spare_v_q;
  assign pop = out_v_q & out_ready;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_q <= '0;
      spare_q <= '0;
      out_v_q <= 1'b0;
      spare_v_q <= 1'b0;
    end else if (ce) begin
      if (pop) begin
        if (spare_v_q) begin
          out_q <= spare_q;
          spare_v_q <= 1'b0;
        end else if (push) begin
          out_q <= in_data;
        end else begin
          out_v_q <= 1'b0;
        end
      end else if (push) begin
        if (!out_v_q) begin
          out_q <= in_data;
          out_v_q <= 1'b1;
        end else begin
          spare_q <= in_data;
          spare_v_q <= 1'b1;
        end
      end
    end
  end

  assign out_valid = out_v_q;
  assign out_data = out_q;
  assign empty = ~out_v_q;
endmodule // sdrbrp_buf

//--- sdrbrp_ctl.sv
`timescale 1ns/1ps
// Operation
// - Read strobe ends with half-cycle postamble regardless of read preamble length.
// - Activate opens row chosen by group select, bank inputs and row address.
// - Row stays open until precharge to its bank or precharge-all.
// - Precharge closes one or all banks; reactivation waits the precharge period.
// - Precharge to idle or precharging bank accepted; period restarts from latest.
// - Auto-precharge bit high on read or write closes bank after burst.
// - Read auto-close is held until active-to-close minimum is met.
// - Write auto-close waits until the last write word reaches the array.
// - Eight-beat read releases data outputs at read latency plus four cycles.
// - Chopped read releases data outputs at read latency plus two cycles.
// - On-the-fly mode: chop bit low selects four beats, high selects eight.
module sdrbrp_ctl
  import sdrbrp_pkg::*;
#(
  parameter int RD_LAT = sdrbrp_pkg::READ_LATENCY_NCK,
  parameter int WR_LAT = sdrbrp_pkg::WRITE_LATENCY_NCK,
  parameter int PRE_NCK = sdrbrp_pkg::PRECHARGE_PERIOD_NCK,
  parameter int RAS_NCK = sdrbrp_pkg::ACTIVE_TO_CLOSE_MIN_NCK
) (
  input wire logic clk, // System clock, 10 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic link_ck, // Link clock from the controller
  input wire logic cs_n, // Chip select, active low
  input wire logic act_n, // Activate, active low
  input wire logic ras_n, // Command bit, active low
  input wire logic cas_n, // Command bit, active low
  input wire logic we_n, // Command bit, active low
  input wire logic bank_group_select, // Bank group
  input wire logic [sdrbrp_pkg::BANK_IDX_W-1:0] bank_index_inputs, // Bank in group
  input wire logic [sdrbrp_pkg::ROW_W-1:0] addr, // Row or column address
  input wire logic [sdrbrp_pkg::DQ_W-1:0] dq_in, // Data pins, input side
  output logic [sdrbrp_pkg::DQ_W-1:0] dq_out, // Data pins, output side
  output logic dq_oe_n, // Data pins drive enable, low drives
  output logic dqs_out, // Strobe, output side
  output logic dqs_oe_n, // Strobe drive enable, low drives
  input wire logic rd_preamble_two, // Two-cycle read preamble selected
  input wire logic burst_otf, // Burst length chosen per command
  input wire logic fixed_chop, // Fixed four-beat bursts when not on the fly
  input wire logic [sdrbrp_pkg::DQ_W-1:0] arr_rdata, // Array word for next read beat
  output logic arr_rbeat, // Pulse: array word consumed
  output logic [sdrbrp_pkg::DQ_W-1:0] arr_wdata, // Write word to array
  output logic arr_wvalid, // Write word valid
  input wire logic arr_wready, // Array accepts write word
  output logic [sdrbrp_pkg::BANKS-1:0] bank_open, // Row open per bank
  output logic [sdrbrp_pkg::BANKS-1:0] bank_precharging, // Precharge running per bank
  output logic cmd_err // Pulse: illegal command or lost word
);
  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] halves_less_one(input int n);
    halves_less_one = CNT_W'(2 * n - 1);
  endfunction

  function automatic logic [CNT_W-1:0] nck_cnt(input int n);
    nck_cnt = CNT_W'(n);
  endfunction

  // ==========================================================
  // Pin synchronisation and link clock edges
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins;
  logic ck_prev_q;
  logic ck_rise;
  logic ck_edge;

  assign pins_raw = {dq_in, addr, bank_index_inputs, bank_group_select,
                     we_n, cas_n, ras_n, act_n, cs_n, link_ck};

  sdrbrp_sync #(.W(PIN_W)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pin_in(pins_raw),
    .pin_out(pins)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ck_prev_q <= 1'b0;
    end else if (ce) begin
      ck_prev_q <= pins[PIN_CK];
    end
  end

  assign ck_rise = pins[PIN_CK] & ~ck_prev_q;
  assign ck_edge = pins[PIN_CK] ^ ck_prev_q;

  // ==========================================================
  // Command decode on link clock rising edges
  sdrbrp_cmd_type cmd;
  logic [BANK_W-1:0] cmd_bank;
  logic [ROW_W-1:0] cmd_addr;
  logic cmd_auto;
  logic cmd_chop;

  assign cmd_bank = {pins[PIN_BG], pins[PIN_BA +: BANK_IDX_W]};
  assign cmd_addr = pins[PIN_ADDR +: ROW_W];
  assign cmd_auto = cmd_addr[AUTO_PRECHARGE_BIT];
  assign cmd_chop = burst_otf ? ~cmd_addr[BURST_CHOP_BIT] : fixed_chop;

  always_comb begin
    cmd = CMD_NONE;
    if (ck_rise && !pins[PIN_CS_N]) begin
      if (!pins[PIN_ACT_N]) begin
        cmd = CMD_ACT;
      end else begin
        case ({pins[PIN_RAS_N], pins[PIN_CAS_N], pins[PIN_WE_N]})
          3'h2: cmd = CMD_PRE;
          3'h5: cmd = CMD_RD;
          3'h4: cmd = CMD_WR;
          default: cmd = CMD_NONE;
        endcase
      end
    end
  end

  // ==========================================================
  // Read engine: wait, preamble, burst, postamble
  sdrbrp_rd_state_type rd_st_q;
  logic [CNT_W-1:0] rd_cnt_q;
  logic rd_chop_q;
  logic [DQ_W-1:0] dq_out_q;
  logic dq_oe_n_q;
  logic dqs_out_q;
  logic dqs_oe_n_q;
  logic rbeat_q;
  logic rd_start;

  assign rd_start = (cmd == CMD_RD) && (rd_st_q == RD_IDLE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_st_q <= RD_IDLE;
      rd_cnt_q <= '0;
      rd_chop_q <= 1'b0;
    end else if (ce) begin
      case (rd_st_q)
        RD_IDLE: begin
          if (rd_start) begin
            rd_chop_q <= cmd_chop;
            rd_st_q <= RD_WAIT;
            rd_cnt_q <= rd_preamble_two ? halves_less_one(RD_LAT - 2)
                                        : halves_less_one(RD_LAT - 1);
          end
        end
        RD_WAIT: begin
          if (ck_edge) begin
            if (rd_cnt_q == '0) begin
              rd_st_q <= RD_PRE;
              rd_cnt_q <= rd_preamble_two ? halves_less_one(2) : halves_less_one(1);
            end else begin
              rd_cnt_q <= rd_cnt_q - 1'b1;
            end
          end
        end
        RD_PRE: begin
          if (ck_edge) begin
            if (rd_cnt_q == '0) begin
              rd_st_q <= RD_BURST;
              rd_cnt_q <= rd_chop_q ? CNT_W'(CHOP_FOUR_HALVES - 1)
                                    : CNT_W'(EIGHT_BEAT_HALVES - 1);
            end else begin
              rd_cnt_q <= rd_cnt_q - 1'b1;
            end
          end
        end
        RD_BURST: begin
          if (ck_edge) begin
            if (rd_cnt_q == '0) begin
              rd_st_q <= RD_POST;
              rd_cnt_q <= CNT_W'(POSTAMBLE_HALVES - 1);
            end else begin
              rd_cnt_q <= rd_cnt_q - 1'b1;
            end
          end
        end
        RD_POST: begin
          if (ck_edge) begin
            if (rd_cnt_q == '0) begin
              rd_st_q <= RD_IDLE;
            end else begin
              rd_cnt_q <= rd_cnt_q - 1'b1;
            end
          end
        end
        default: rd_st_q <= RD_IDLE;
      endcase
    end
  end

  // Pin drive follows the state entered on each link edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_out_q <= '0;
      dq_oe_n_q <= 1'b1;
      dqs_out_q <= 1'b0;
      dqs_oe_n_q <= 1'b1;
      rbeat_q <= 1'b0;
    end else if (ce) begin
      rbeat_q <= 1'b0;
      if (ck_edge && rd_cnt_q == '0) begin
        case (rd_st_q)
          RD_WAIT: begin
            dqs_oe_n_q <= 1'b0;
            dqs_out_q <= 1'b0;
          end
          RD_PRE: begin
            dq_oe_n_q <= 1'b0;
            dq_out_q <= arr_rdata;
            dqs_out_q <= 1'b1;
            rbeat_q <= 1'b1;
          end
          RD_BURST: begin
            dq_oe_n_q <= 1'b1;
            dqs_out_q <= 1'b0;
          end
          RD_POST: begin
            dqs_oe_n_q <= 1'b1;
          end
          default: dqs_oe_n_q <= dqs_oe_n_q;
        endcase
      end else if (ck_edge && rd_st_q == RD_BURST) begin
        dq_out_q <= arr_rdata;
        dqs_out_q <= ~dqs_out_q;
        rbeat_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Write engine: capture one word per link edge into the buffer
  sdrbrp_wr_state_type wr_st_q;
  logic [CNT_W-1:0] wr_cnt_q;
  logic wr_chop_q;
  logic cap_valid;
  logic buf_ready;
  logic buf_empty;

  assign cap_valid = ck_edge && ((wr_st_q == WR_BURST) ||
                     (wr_st_q == WR_WAIT && wr_cnt_q == '0));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_st_q <= WR_IDLE;
      wr_cnt_q <= '0;
      wr_chop_q <= 1'b0;
    end else if (ce) begin
      case (wr_st_q)
        WR_IDLE: begin
          if (cmd == CMD_WR) begin
            wr_chop_q <= cmd_chop;
            wr_st_q <= WR_WAIT;
            wr_cnt_q <= halves_less_one(WR_LAT);
          end
        end
        WR_WAIT: begin
          if (ck_edge) begin
            if (wr_cnt_q == '0) begin
              wr_st_q <= WR_BURST;
              wr_cnt_q <= wr_chop_q ? CNT_W'(CHOP_FOUR_HALVES - 2)
                                    : CNT_W'(EIGHT_BEAT_HALVES - 2);
            end else begin
              wr_cnt_q <= wr_cnt_q - 1'b1;
            end
          end
        end
        WR_BURST: begin
          if (ck_edge) begin
            if (wr_cnt_q == '0) begin
              wr_st_q <= WR_IDLE;
            end else begin
              wr_cnt_q <= wr_cnt_q - 1'b1;
            end
          end
        end
        default: wr_st_q <= WR_IDLE;
      endcase
    end
  end

  sdrbrp_buf #(.W(DQ_W)) u_wbuf (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(cap_valid),
    .in_ready(buf_ready),
    .in_data(pins[PIN_DQ +: DQ_W]),
    .out_valid(arr_wvalid),
    .out_ready(arr_wready),
    .out_data(arr_wdata),
    .empty(buf_empty)
  );

  // ==========================================================
  // Per-bank row state, active-to-close and precharge timers
  logic [BANKS-1:0] open_q;
  logic [ROW_W-1:0] row_q [BANKS];
  logic [CNT_W-1:0] ras_cnt_q [BANKS];
  logic [CNT_W-1:0] rp_cnt_q [BANKS];
  logic [BANKS-1:0] ap_wait_q;
  logic [BANKS-1:0] ap_wr_q;
  logic [BANKS-1:0] prechg_q;
  logic err_q;
  logic rd_done;
  logic wr_done;

  assign rd_done = (rd_st_q == RD_IDLE);
  assign wr_done = (wr_st_q == WR_IDLE) && buf_empty;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      open_q <= '0;
      ap_wait_q <= '0;
      ap_wr_q <= '0;
      prechg_q <= '0;
      for (int b = 0; b < BANKS; b++) begin
        row_q[b] <= '0;
        ras_cnt_q[b] <= '0;
        rp_cnt_q[b] <= '0;
      end
    end else if (ce) begin
      for (int b = 0; b < BANKS; b++) begin
        prechg_q[b] <= (rp_cnt_q[b] != '0);
        if (ck_rise && ras_cnt_q[b] != '0) begin
          ras_cnt_q[b] <= ras_cnt_q[b] - 1'b1;
        end
        if (ck_rise && rp_cnt_q[b] != '0) begin
          rp_cnt_q[b] <= rp_cnt_q[b] - 1'b1;
        end
        // Hidden precharge once data and active-to-close time allow it
        if (ap_wait_q[b] && ras_cnt_q[b] == '0 &&
            (ap_wr_q[b] ? wr_done : rd_done)) begin
          open_q[b] <= 1'b0;
          ap_wait_q[b] <= 1'b0;
          rp_cnt_q[b] <= nck_cnt(PRE_NCK);
        end
        if (cmd == CMD_PRE && (cmd_auto || cmd_bank == BANK_W'(b))) begin
          open_q[b] <= 1'b0;
          ap_wait_q[b] <= 1'b0;
          rp_cnt_q[b] <= nck_cnt(PRE_NCK);
        end
        if (cmd_bank == BANK_W'(b)) begin
          if (cmd == CMD_ACT && !open_q[b] && rp_cnt_q[b] == '0) begin
            open_q[b] <= 1'b1;
            row_q[b] <= cmd_addr;
            ras_cnt_q[b] <= nck_cnt(RAS_NCK);
          end
          if ((cmd == CMD_RD || cmd == CMD_WR) && open_q[b] && !ap_wait_q[b] &&
              cmd_auto) begin
            ap_wait_q[b] <= 1'b1;
            ap_wr_q[b] <= (cmd == CMD_WR);
          end
        end
      end
    end
  end

  // Commands that break the controller's obligations are flagged; refused activates and reads or writes that find their engine busy are dropped, others run
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_q <= 1'b0;
    end else if (ce) begin
      err_q <= ((cmd == CMD_ACT) && (open_q[cmd_bank] ||
                rp_cnt_q[cmd_bank] != '0)) ||
               ((cmd == CMD_RD || cmd == CMD_WR) && (!open_q[cmd_bank] ||
                ap_wait_q[cmd_bank])) ||
               ((cmd == CMD_RD) && !rd_start) ||
               (cap_valid && !buf_ready);
    end
  end

  // ==========================================================
  // Outputs
  assign dq_out = dq_out_q;
  assign dq_oe_n = dq_oe_n_q;
  assign dqs_out = dqs_out_q;
  assign dqs_oe_n = dqs_oe_n_q;
  assign arr_rbeat = rbeat_q;
  assign bank_open = open_q;
  assign bank_precharging = prechg_q;
  assign cmd_err = err_q;
endmodule // sdrbrp_ctl

//--- sdrbrp_ctl_checker.sv
`timescale 1ns/1ps
// ========
// Port checks for the bank, read and write paths
module sdrbrp_ctl_checker
  import sdrbrp_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic dq_oe_n, // Data drive
  input wire logic dqs_out, // Strobe
  input wire logic dqs_oe_n, // Strobe drive
  input wire logic [sdrbrp_pkg::DQ_W-1:0] dq_out, // Read word
  input wire logic [sdrbrp_pkg::DQ_W-1:0] arr_rdata, // Array word
  input wire logic arr_rbeat, // Beat taken
  input wire logic [sdrbrp_pkg::DQ_W-1:0] arr_wdata, // Write word
  input wire logic arr_wvalid, // Write valid
  input wire logic arr_wready, // Write ready
  input wire logic [sdrbrp_pkg::BANKS-1:0] bank_open, // Open rows
  input wire logic [sdrbrp_pkg::BANKS-1:0] bank_precharging // Timers
);
  localparam int HALF = 4;
  logic [7:0] drive_cnt_q;
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Clocks spent driving the data pins
  always_ff @(posedge clk) begin
    if (sys_rst || dq_oe_n) begin
      drive_cnt_q <= 8'h00;
    end else begin
      drive_cnt_q <= drive_cnt_q + 8'h01;
    end
  end
  chk_drive_span: assert property (
    $rose(dq_oe_n) |-> drive_cnt_q == 8 * HALF || drive_cnt_q == 4 * HALF)
    else $error("data drive span wrong");
  chk_post_low: assert property ($rose(dq_oe_n) |-> !dqs_out && !dqs_oe_n)
    else $error("postamble strobe not low");
  chk_post_half: assert property (
    $rose(dq_oe_n) |-> !dqs_oe_n[*3] ##[1:2] dqs_oe_n)
    else $error("postamble length wrong");
  chk_oe_pair: assert property (!dq_oe_n |-> !dqs_oe_n)
    else $error("data driven without strobe");
  chk_beat_edge: assert property (arr_rbeat |-> $changed(dqs_out) && !dq_oe_n)
    else $error("beat without strobe edge");
  chk_beat_data: assert property (arr_rbeat |-> dq_out == $past(arr_rdata))
    else $error("read word differs from array");
  chk_beat_gap: assert property (arr_rbeat |=> !arr_rbeat[*3])
    else $error("beats too close");
  chk_close_prech: assert property (
    (|($past(bank_open) & ~bank_open)) |=> ((bank_precharging & $past(bank_open, 2))
      == ($past(bank_open, 2) & ~$past(bank_open))))
    else $error("closed bank not precharging");
  chk_one_open: assert property ($countones(bank_open & ~$past(bank_open)) <= 1)
    else $error("several banks opened at once");
  chk_open_excl: assert property ((bank_open & bank_precharging) == '0)
    else $error("bank open while precharging");
  chk_wr_hold: assert property (
    arr_wvalid && !arr_wready |=> arr_wvalid && $stable(arr_wdata))
    else $error("write word dropped while stalled");
endmodule // sdrbrp_ctl_checker

bind sdrbrp_ctl sdrbrp_ctl_checker chk_u (
  .clk(clk), .sys_rst(sys_rst), .dq_oe_n(dq_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n),
  .dq_out(dq_out), .arr_rdata(arr_rdata), .arr_rbeat(arr_rbeat), .arr_wdata(arr_wdata),
  .arr_wvalid(arr_wvalid), .arr_wready(arr_wready), .bank_open(bank_open),
  .bank_precharging(bank_precharging)
);

//--- sdrbrp_mc_model.sv
`timescale 1ns/1ps
// ========
// Controller stand-in: link clock, command pins and write words
module sdrbrp_mc_model
  import sdrbrp_pkg::*;
#(
  parameter int WL = 3
) (
  input wire logic clk, // Clock
  output logic link_ck, // Link clock
  output logic cs_n, // Select
  output logic act_n, // Activate
  output logic ras_n, // Command
  output logic cas_n, // Command
  output logic we_n, // Command
  output logic bank_group_select, // Group
  output logic [sdrbrp_pkg::BANK_IDX_W-1:0] bank_index_inputs, // Bank
  output logic [sdrbrp_pkg::ROW_W-1:0] addr, // Address
  output logic [sdrbrp_pkg::DQ_W-1:0] dq_in // Write data
);
  logic [DQ_W-1:0] wq[$];
  logic [3:0] p_ctl = 4'hF;
  logic [BANK_W-1:0] p_bank = '0;
  logic [ROW_W-1:0] p_addr = '0;
  int hc = 0;
  int wr_from = 1 << 30;
  initial begin
    link_ck = 1'b0;
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
    {bank_group_select, bank_index_inputs, addr, dq_in} = '0;
  end
  // Link stands still between calls; pins move only with a link edge
  task automatic half();
    @(negedge clk);
    link_ck = ~link_ck;
    hc++;
    if (link_ck) begin
      cs_n = (p_ctl == 4'hF);
      {act_n, ras_n, cas_n, we_n} = p_ctl;
      {bank_group_select, bank_index_inputs} = p_bank;
      addr = p_addr;
      p_ctl = 4'hF;
    end else begin
      cs_n = 1'b1;
      addr = ~addr;
    end
    if (hc >= wr_from && wq.size() > 0) begin
      dq_in = wq.pop_front();
    end else begin
      dq_in = ~dq_in;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic run(input int n);
    repeat (2 * n) half();
  endtask
  task automatic cmd(input sdrbrp_cmd_type k, input logic [BANK_W-1:0] b,
                     input logic [ROW_W-1:0] a);
    case (k)
      CMD_ACT: p_ctl = 4'b0111;
      CMD_PRE: p_ctl = 4'b1010;
      CMD_RD: p_ctl = 4'b1101;
      CMD_WR: p_ctl = 4'b1100;
      default: p_ctl = 4'hF;
    endcase
    p_bank = b;
    p_addr = a;
    if (k == CMD_WR) begin
      wr_from = hc + 1 + 2 * WL;
    end
    run(1);
  endtask
endmodule // sdrbrp_mc_model

//--- test_sdrbrp_ctl.sv
`timescale 1ns/1ps
// ========
// Bank, read and write path against a small reference
module test_sdrbrp_ctl;
  import sdrbrp_pkg::*;
  localparam int RD_NCK = 4;
  localparam int WL = 3;
  localparam int PRE = 3;
  localparam int RAS = 16;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic link_ck, cs_n, act_n, ras_n, cas_n, we_n, bank_group_select;
  logic [BANK_IDX_W-1:0] bank_index_inputs;
  logic [ROW_W-1:0] addr;
  logic [DQ_W-1:0] dq_in, dq_out, arr_wdata, arr_rdata = 16'h0000;
  logic dq_oe_n, dqs_out, dqs_oe_n, arr_rbeat, arr_wvalid, cmd_err;
  logic rd_preamble_two = 1'b0, burst_otf = 1'b1, fixed_chop = 1'b0;
  logic arr_wready = 1'b1, wmode = 1'b1;
  logic [BANKS-1:0] bank_open, bank_precharging, exp_open = '0;
  logic [DQ_W-1:0] wexp[$];
  int seed = 32'hA0FC0AF1;
  int n_mismatch = 0, cmp_count = 0, n_err = 0, exp_err = 0, nbeat = 0;

  always #50 clk = ~clk;

  sdrbrp_ctl #(.RD_LAT(RD_NCK), .WR_LAT(WL), .PRE_NCK(PRE), .RAS_NCK(RAS)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .link_ck(link_ck), .cs_n(cs_n), .act_n(act_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_group_select(bank_group_select),
    .bank_index_inputs(bank_index_inputs), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n),
    .rd_preamble_two(rd_preamble_two), .burst_otf(burst_otf), .fixed_chop(fixed_chop),
    .arr_rdata(arr_rdata), .arr_rbeat(arr_rbeat), .arr_wdata(arr_wdata),
    .arr_wvalid(arr_wvalid), .arr_wready(arr_wready), .bank_open(bank_open),
    .bank_precharging(bank_precharging), .cmd_err(cmd_err)
  );
  sdrbrp_mc_model #(.WL(WL)) mc_u (
    .clk(clk), .link_ck(link_ck), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_group_select(bank_group_select),
    .bank_index_inputs(bank_index_inputs), .addr(addr), .dq_in(dq_in)
  );

  task automatic chk_bits(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic done(input string name);
    chk_bits("bank_open", 32'(exp_open), 32'(bank_open));
    chk_bits("cmd_err count", exp_err, n_err);
    $display("test %s finished", name);
  endtask
  task automatic act(input int b);
    mc_u.cmd(CMD_ACT, b[BANK_W-1:0], ROW_W'($random(seed)));
    exp_open[b] = 1'b1;
  endtask
  task automatic wr(input int b, input logic [ROW_W-1:0] a, input int keep);
    logic [DQ_W-1:0] w;
    for (int i = 0; i < 8; i++) begin
      w = DQ_W'($random(seed));
      mc_u.wq.push_back(w);
      if (i < keep) wexp.push_back(w);
    end
    mc_u.cmd(CMD_WR, b[BANK_W-1:0], a);
  endtask

  // ========
  // Array side and error monitors
  always @(negedge clk) begin
    if (arr_rbeat === 1'b1) begin
      chk_word("dq_out", arr_rdata, dq_out);
      nbeat++;
      arr_rdata <= DQ_W'($random(seed));
    end
    arr_wready <= wmode && (!arr_wready || $random(seed) % 2 != 0);
  end
  always @(posedge clk) begin
    if (!sys_rst && arr_wvalid === 1'b1 && arr_wready) begin
      chk_word("arr_wdata", wexp.size() > 0 ? wexp.pop_front() : ~arr_wdata, arr_wdata);
    end
    if (!sys_rst && cmd_err === 1'b1) n_err++;
  end

  initial begin
    int b;
    int m;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    chk_bits("idle drive enables", 32'h3, 32'({dq_oe_n, dqs_oe_n}));
    done("reset");
    for (b = 0; b < BANKS; b++) begin
      act(b);
      chk_bits("bank_open", 32'(exp_open), 32'(bank_open));
    end
    mc_u.cmd(CMD_ACT, 3'h5, 15'h1234);
    exp_err++;
    done("activate open bank");
    mc_u.cmd(CMD_PRE, 3'h2, 15'h0000);
    exp_open[2] = 1'b0;
    chk_bits("bank_precharging", 32'h4, 32'(bank_precharging));
    mc_u.cmd(CMD_PRE, 3'h2, 15'h0000);
    mc_u.cmd(CMD_ACT, 3'h2, 15'h0000);
    exp_err++;
    done("precharge");
    mc_u.run(PRE);
    act(2);
    done("reactivate");
    for (m = 0; m < 4; m++) begin
      burst_otf = m[1];
      fixed_chop = m[0];
      rd_preamble_two = m[1] ^ m[0];
      nbeat = 0;
      mc_u.cmd(CMD_RD, 3'h0, {2'b00, m[0], 12'h000});
      mc_u.run(RD_NCK + 5);
      chk_bits("beats", (m[1] == m[0]) ? 8 : 4, nbeat);
    end
    done("reads");
    mc_u.cmd(CMD_PRE, 3'h4, 15'h0000);
    exp_open[4] = 1'b0;
    mc_u.run(PRE);
    act(4);
    mc_u.cmd(CMD_RD, 3'h4, 15'h1400);
    mc_u.run(RD_NCK + 5);
    done("read autoclose hold");
    mc_u.cmd(CMD_RD, 3'h0, 15'h1000);
    mc_u.run(RAS);
    exp_open[4] = 1'b0;
    done("read autoclose");
    wr(1, 15'h1000, 8);
    mc_u.run(WL + 6);
    chk_bits("words left", 0, wexp.size());
    done("write");
    wmode = 1'b0;
    wr(3, 15'h0400, 2);
    exp_err += 2;
    mc_u.run(WL + 8);
    done("write stall");
    wmode = 1'b1;
    mc_u.run(PRE + 2);
    exp_open[3] = 1'b0;
    chk_bits("words left", 0, wexp.size());
    done("write autoclose");
    mc_u.cmd(CMD_PRE, 3'h0, 15'h0400);
    exp_open = '0;
    done("precharge all");
    mc_u.cmd(CMD_RD, 3'h6, 15'h1000);
    exp_err++;
    mc_u.run(RD_NCK + 5);
    done("read idle bank");
    ce = 1'b0;
    act(5);
    exp_open[5] = 1'b0;
    ce = 1'b1;
    done("clock enable low");
    close_out();
  end

  initial begin
    #1_000_000;
    n_mismatch++;
    close_out();
  end
endmodule // test_sdrbrp_ctl
